// >>> design/scl_static_config_lock.sv
// static configuration register bank with freeze, dual-copy check, calibration and clamp timing
`timescale 1ns/1ps
module scl_static_config_lock #(
   parameter int CLAMP_DIV = scl_pkg::CLAMP_TICK_CYC,
   parameter int CAL_W = scl_pkg::DELAY_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic reset_event_i,
   input wire logic [2:0] mode_i,
   input wire logic leave_configuration_command_i,
   input wire logic wr_i,
   input wire logic [scl_pkg::REG_IDX_W-1:0] wr_idx_i,
   input wire logic [scl_pkg::DATA_W-1:0] wr_data_i,
   input wire logic rx_valid_i,
   input wire logic [scl_pkg::DATA_W-1:0] rx_word_i,
   input wire logic [scl_pkg::DATA_W-2:0] tx_data_i,
   input wire logic pwm_i,
   input wire logic osc_i,
   input wire logic pwm_off_cmd_i,
   input wire logic blanking_active_i,
   output logic frozen_o,
   output logic write_discarded_o,
   output logic reset_event_o,
   output logic class_b_event_o,
   output logic rx_parity_err_o,
   output logic [scl_pkg::DATA_W-1:0] tx_word_o,
   output logic receive_parity_enable_o,
   output logic base_emitter_compensation_enable_o,
   output logic pulse_suppressor_enable_o,
   output logic verification_timeout_select_o,
   output logic sense_clamp_o,
   output logic [scl_pkg::DELAY_W-1:0] regular_delay_value_o,
   output logic [scl_pkg::DELAY_W-1:0] safe_delay_value_o,
   output logic [scl_pkg::PLATEAU_W-1:0] regular_plateau_level_o,
   output logic [scl_pkg::PLATEAU_W-1:0] safe_plateau_level_o,
   output logic regular_two_level_turn_off_o,
   output logic safe_two_level_turn_off_o,
   output logic [scl_pkg::FIELD8_W-1:0] saturation_blanking_a_o,
   output logic [scl_pkg::FIELD8_W-1:0] saturation_blanking_b_o,
   output logic [scl_pkg::FIELD8_W-1:0] overcurrent_blanking_field_o,
   output logic overcurrent_immediate_o,
   output logic calibration_enable_field_o,
   output logic calibration_done_o,
   output logic active_clamp_control_output_o
);
   localparam int N = scl_pkg::REG_COUNT;
   localparam int DIV_W = $clog2(CLAMP_DIV + 1);

   // any reset event clears everything a user wrote
   logic clr;
   assign clr = rst_i || reset_event_i;

   // ---------------- pin synchronisers ----------------
   logic [1:0] pwm_sync_d;
   logic [1:0] pwm_sync_q;
   logic [1:0] osc_sync_d;
   logic [1:0] osc_sync_q;
   logic pwm_prev_d;
   logic pwm_prev_q;
   logic osc_prev_d;
   logic osc_prev_q;
   logic pwm_rise;
   logic pwm_fall;
   logic osc_rise;
   always_comb begin
      pwm_sync_d = {pwm_sync_q[0], pwm_i};
      osc_sync_d = {osc_sync_q[0], osc_i};
      pwm_prev_d = pwm_sync_q[1];
      osc_prev_d = osc_sync_q[1];
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwm_sync_q <= 2'h0;
         osc_sync_q <= 2'h0;
         pwm_prev_q <= 1'b0;
         osc_prev_q <= 1'b0;
      end else begin
         pwm_sync_q <= pwm_sync_d;
         osc_sync_q <= osc_sync_d;
         pwm_prev_q <= pwm_prev_d;
         osc_prev_q <= osc_prev_d;
      end
   end
   assign pwm_rise = pwm_sync_q[1] && !pwm_prev_q;
   assign pwm_fall = !pwm_sync_q[1] && pwm_prev_q;
   assign osc_rise = osc_sync_q[1] && !osc_prev_q;

   // ---------------- calibration counter ----------------
   scl_pkg::scl_cal_state_t cal_state_d;
   scl_pkg::scl_cal_state_t cal_state_q;
   logic [CAL_W-1:0] cal_cnt_d;
   logic [CAL_W-1:0] cal_cnt_q;
   logic cal_write;
   logic cal_done_d;
   logic cal_done_q;
   logic cal_allowed;
   assign cal_allowed = (mode_i == scl_pkg::MODE_CALIBRATION) && calibration_enable_field_o;
   always_comb begin
      cal_state_d = cal_state_q;
      cal_cnt_d = cal_cnt_q;
      cal_write = 1'b0;
      cal_done_d = cal_done_q;
      unique case (cal_state_q)
         scl_pkg::SCL_CAL_IDLE: begin
            // a pulse already high on entry is skipped; counting starts on a clean rising edge
            if (cal_allowed && !pwm_sync_q[1]) begin
               cal_state_d = scl_pkg::SCL_CAL_ARMED;
            end
         end
         scl_pkg::SCL_CAL_ARMED: begin
            if (!cal_allowed) begin
               cal_state_d = scl_pkg::SCL_CAL_IDLE;
            end else if (pwm_rise) begin
               cal_cnt_d = '0;
               cal_state_d = scl_pkg::SCL_CAL_COUNT;
            end
         end
         scl_pkg::SCL_CAL_COUNT: begin
            if (!cal_allowed) begin
               cal_state_d = scl_pkg::SCL_CAL_IDLE;
            end else if (pwm_fall) begin
               cal_write = 1'b1;
               cal_done_d = 1'b1;
               cal_state_d = scl_pkg::SCL_CAL_ARMED;
            end else if (osc_rise && !(&cal_cnt_q)) begin
               // saturates instead of wrapping so a long pulse gives the largest delay
               cal_cnt_d = cal_cnt_q + 1'b1;
            end
         end
         default: begin
            cal_state_d = scl_pkg::SCL_CAL_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (clr) begin
         cal_state_q <= scl_pkg::SCL_CAL_IDLE;
         cal_cnt_q <= '0;
         cal_done_q <= 1'b0;
      end else begin
         cal_state_q <= cal_state_d;
         cal_cnt_q <= cal_cnt_d;
         cal_done_q <= cal_done_d;
      end
   end

   // ---------------- registers, shadow copy and freeze ----------------
   logic [scl_pkg::DATA_W-1:0] cfg_d [N];
   logic [scl_pkg::DATA_W-1:0] cfg_q [N];
   logic [scl_pkg::DATA_W-1:0] shadow_d [N];
   logic [scl_pkg::DATA_W-1:0] shadow_q [N];
   logic frozen_d;
   logic frozen_q;
   logic discard_d;
   logic discard_q;
   logic mismatch_d;
   logic mismatch_q;
   logic write_ok;
   logic [scl_pkg::DATA_W-1:0] cal_word;
   always_comb begin
      write_ok = wr_i && (mode_i == scl_pkg::MODE_CONFIGURATION) && !frozen_q;
      discard_d = wr_i && (wr_idx_i < scl_pkg::REG_IDX_W'(N)) && !write_ok;
      frozen_d = frozen_q;
      // freeze only through the command that leaves configuration mode
      if (leave_configuration_command_i && (mode_i == scl_pkg::MODE_CONFIGURATION)) begin
         frozen_d = 1'b1;
      end
      cal_word = cfg_q[scl_pkg::IDX_REGULAR_TURN_OFF];
      cal_word[scl_pkg::DELAY_LSB +: scl_pkg::DELAY_W] = scl_pkg::DELAY_W'(cal_cnt_q);
      mismatch_d = 1'b0;
      for (int i = 0; i < N; i++) begin
         cfg_d[i] = cfg_q[i];
         shadow_d[i] = shadow_q[i];
         if (write_ok && (wr_idx_i == scl_pkg::REG_IDX_W'(i))) begin
            // both dies take the same word
            cfg_d[i] = wr_data_i;
            shadow_d[i] = wr_data_i;
         end
         if (cal_write && (scl_pkg::REG_IDX_W'(i) == scl_pkg::IDX_REGULAR_TURN_OFF)) begin
            cfg_d[i] = cal_word;
            shadow_d[i] = cal_word;
         end
         if (cfg_q[i] != shadow_q[i]) begin
            mismatch_d = 1'b1;
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (clr) begin
         for (int i = 0; i < N; i++) begin
            cfg_q[i] <= scl_pkg::reset_value(scl_pkg::REG_IDX_W'(i));
            shadow_q[i] <= scl_pkg::reset_value(scl_pkg::REG_IDX_W'(i));
         end
         frozen_q <= 1'b0;
         discard_q <= 1'b0;
         mismatch_q <= 1'b0;
      end else begin
         for (int i = 0; i < N; i++) begin
            cfg_q[i] <= cfg_d[i];
            shadow_q[i] <= shadow_d[i];
         end
         frozen_q <= frozen_d;
         discard_q <= discard_d;
         mismatch_q <= mismatch_d;
      end
   end

   // ---------------- derived outputs ----------------
   logic [scl_pkg::DATA_W-1:0] prim;
   logic [scl_pkg::DATA_W-1:0] sec;
   logic [scl_pkg::DATA_W-1:0] reg_to;
   logic [scl_pkg::DATA_W-1:0] safe_to;
   logic [scl_pkg::FIELD8_W-1:0] oc_bt;
   logic [scl_pkg::FIELD8_W-1:0] clamp_at;
   assign prim = cfg_q[scl_pkg::IDX_PRIMARY_CFG];
   assign sec = cfg_q[scl_pkg::IDX_SECONDARY_CFG];
   assign reg_to = cfg_q[scl_pkg::IDX_REGULAR_TURN_OFF];
   assign safe_to = cfg_q[scl_pkg::IDX_SAFE_TURN_OFF];
   assign oc_bt = cfg_q[scl_pkg::IDX_OVERCURRENT][scl_pkg::FIELD8_W-1:0];
   assign clamp_at = cfg_q[scl_pkg::IDX_CLAMP_TIMING][scl_pkg::FIELD8_W-1:0];

   logic sense_d;
   logic reg_tl_d;
   logic safe_tl_d;
   logic oc_imm_d;
   logic sense_q;
   logic reg_tl_q;
   logic safe_tl_q;
   logic oc_imm_q;
   always_comb begin
      sense_d = blanking_active_i || (sec[scl_pkg::BIT_SENSE_CLAMP] && pwm_off_cmd_i);
      reg_tl_d = reg_to[scl_pkg::DELAY_LSB +: scl_pkg::DELAY_W] != scl_pkg::ZERO8;
      safe_tl_d = safe_to[scl_pkg::DELAY_LSB +: scl_pkg::DELAY_W] != scl_pkg::ZERO8;
      oc_imm_d = oc_bt == scl_pkg::ZERO8;
   end
   always_ff @(posedge clk_i) begin
      if (clr) begin
         sense_q <= 1'b0;
         reg_tl_q <= 1'b0;
         safe_tl_q <= 1'b0;
         oc_imm_q <= 1'b1;
      end else begin
         sense_q <= sense_d;
         reg_tl_q <= reg_tl_d;
         safe_tl_q <= safe_tl_d;
         oc_imm_q <= oc_imm_d;
      end
   end

   // ---------------- active clamp activation timer ----------------
   logic [DIV_W-1:0] div_d;
   logic [DIV_W-1:0] div_q;
   logic [scl_pkg::FIELD8_W-1:0] at_cnt_d;
   logic [scl_pkg::FIELD8_W-1:0] at_cnt_q;
   logic clamp_d;
   logic clamp_q;
   logic tick;
   always_comb begin
      tick = div_q == DIV_W'(CLAMP_DIV - 1);
      div_d = tick ? '0 : div_q + 1'b1;
      at_cnt_d = at_cnt_q;
      if (pwm_fall || (pwm_rise && (at_cnt_q != scl_pkg::ZERO8))) begin
         // hard commutation loads; a turn-on pulse while running reloads rather than cancels
         at_cnt_d = clamp_at;
      end else if (tick && (at_cnt_q != scl_pkg::ZERO8)) begin
         at_cnt_d = at_cnt_q - 1'b1;
      end
      if (clamp_at == scl_pkg::ZERO8) begin
         clamp_d = 1'b1;
      end else if (clamp_at == scl_pkg::ALL_ONES8) begin
         clamp_d = 1'b0;
      end else begin
         // low while the activation window runs
         clamp_d = at_cnt_d == scl_pkg::ZERO8;
      end
   end
   always_ff @(posedge clk_i) begin
      if (clr) begin
         div_q <= '0;
         at_cnt_q <= '0;
         clamp_q <= 1'b1;
      end else begin
         div_q <= div_d;
         at_cnt_q <= at_cnt_d;
         clamp_q <= clamp_d;
      end
   end

   scl_parity #(
      .WORD_W(scl_pkg::DATA_W)
   ) u_parity (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .parity_en_i(prim[scl_pkg::BIT_PARITY_EN]),
      .rx_valid_i(rx_valid_i),
      .rx_word_i(rx_word_i),
      .tx_data_i(tx_data_i),
      .rx_parity_err_o(rx_parity_err_o),
      .tx_word_o(tx_word_o)
   );

   assign frozen_o = frozen_q;
   assign write_discarded_o = discard_q;
   assign reset_event_o = mismatch_q;
   assign class_b_event_o = mismatch_q;
   assign receive_parity_enable_o = prim[scl_pkg::BIT_PARITY_EN];
   assign base_emitter_compensation_enable_o = sec[scl_pkg::BIT_BE_COMP];
   assign pulse_suppressor_enable_o = sec[scl_pkg::BIT_PULSE_SUPP];
   assign verification_timeout_select_o = sec[scl_pkg::BIT_TIMEOUT_SEL];
   assign sense_clamp_o = sense_q;
   assign regular_delay_value_o = reg_to[scl_pkg::DELAY_LSB +: scl_pkg::DELAY_W];
   assign safe_delay_value_o = safe_to[scl_pkg::DELAY_LSB +: scl_pkg::DELAY_W];
   assign regular_plateau_level_o = reg_to[scl_pkg::PLATEAU_LSB +: scl_pkg::PLATEAU_W];
   assign safe_plateau_level_o = safe_to[scl_pkg::PLATEAU_LSB +: scl_pkg::PLATEAU_W];
   assign regular_two_level_turn_off_o = reg_tl_q;
   assign safe_two_level_turn_off_o = safe_tl_q;
   assign saturation_blanking_a_o = cfg_q[scl_pkg::IDX_BLANKING_A][scl_pkg::FIELD8_W-1:0];
   assign saturation_blanking_b_o = cfg_q[scl_pkg::IDX_BLANKING_B][scl_pkg::FIELD8_W-1:0];
   assign overcurrent_blanking_field_o = oc_bt;
   assign overcurrent_immediate_o = oc_imm_q;
   assign calibration_enable_field_o = cfg_q[scl_pkg::IDX_SPECIAL_CONTROL][scl_pkg::BIT_CAL_EN];
   assign calibration_done_o = cal_done_q;
   assign active_clamp_control_output_o = clamp_q;
endmodule

// >>> design/scl_pkg_parity.sv
// shared constants for the static configuration lock and its spi word parity unit
// Functional notes
// - static configuration writes are taken only in configuration mode.
// - leaving configuration by command freezes both copies to host writes, which are then dropped; calibration can still set regular delay.
// - both copies are compared continuously; mismatch raises reset and class b events.
// - odd receive parity is checked by default; the enable bit switches it.
// - transmit words always carry a parity bit.
// - one bit enables base-emitter compensation on the turn-on and turn-off outputs.
// - clamp bit set holds sense pin in pwm-off and blanking; clear only blanking.
// - one bit enables the pulse suppressor; software keeps regular delay above minimum.
// - one bit selects the verification mode timeout duration.
// - regular and safe turn-off delays live apart; calibration may set regular.
// - zero delay disables two-level turn-off, giving hard turn-off instead.
// - two blanking registers hold saturation blanking; software respects the minimum.
// - zero overcurrent blanking means immediate reaction; software respects the maximum.
// - clamp output high when field zero, low when all ones, else timed.
// - a new turn-on pulse restarts a running clamp activation rather than cancelling it.
// - calibration counts oscillator edges over the pwm pulse into regular delay.
// - every reset event restores register defaults and clears the freeze.
package scl_pkg;
   localparam int REG_IDX_W = 4;
   localparam int DATA_W = 16;
   localparam int REG_COUNT = 9;
   localparam logic [3:0] IDX_PRIMARY_CFG = 4'h0;
   localparam logic [3:0] IDX_SECONDARY_CFG = 4'h1;
   localparam logic [3:0] IDX_REGULAR_TURN_OFF = 4'h2;
   localparam logic [3:0] IDX_SAFE_TURN_OFF = 4'h3;
   localparam logic [3:0] IDX_BLANKING_A = 4'h4;
   localparam logic [3:0] IDX_BLANKING_B = 4'h5;
   localparam logic [3:0] IDX_OVERCURRENT = 4'h6;
   localparam logic [3:0] IDX_CLAMP_TIMING = 4'h7;
   localparam logic [3:0] IDX_SPECIAL_CONTROL = 4'h8;
   // field positions
   localparam int BIT_PARITY_EN = 0;
   localparam int BIT_BE_COMP = 0;
   localparam int BIT_SENSE_CLAMP = 1;
   localparam int BIT_PULSE_SUPP = 2;
   localparam int BIT_TIMEOUT_SEL = 3;
   localparam int BIT_CAL_EN = 0;
   localparam int DELAY_LSB = 0;
   localparam int DELAY_W = 8;
   localparam int PLATEAU_LSB = 8;
   localparam int PLATEAU_W = 4;
   localparam int FIELD8_W = 8;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [7:0] ALL_ONES8 = 8'hFF;
   // reset values
   localparam logic [15:0] RST_PRIMARY_CFG = 16'h0001;
   localparam logic [15:0] RST_OTHER = 16'h0000;
   // operating mode codes as presented by the mode state machine
   localparam logic [2:0] MODE_INITIAL = 3'h0;
   localparam logic [2:0] MODE_CONFIGURATION = 3'h2;
   localparam logic [2:0] MODE_NORMAL = 3'h4;
   localparam logic [2:0] MODE_CALIBRATION = 3'h6;
   // clamp activation time base
   localparam int CLK_MHZ = 200;
   localparam int CLAMP_TICK_NS = 1000;
   localparam int CLAMP_TICK_CYC = (CLAMP_TICK_NS * CLK_MHZ) / 1000;
   typedef enum logic [1:0] {
      SCL_CAL_IDLE = 2'h0,
      SCL_CAL_ARMED = 2'h1,
      SCL_CAL_COUNT = 2'h3
   } scl_cal_state_t;
   function automatic logic [15:0] reset_value(input logic [3:0] idx);
      reset_value = (idx == IDX_PRIMARY_CFG) ? RST_PRIMARY_CFG : RST_OTHER;
   endfunction
endpackage

`timescale 1ns/1ps
module scl_parity #(
   parameter int WORD_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic parity_en_i,
   input wire logic rx_valid_i,
   input wire logic [WORD_W-1:0] rx_word_i,
   input wire logic [WORD_W-2:0] tx_data_i,
   output logic rx_parity_err_o,
   output logic [WORD_W-1:0] tx_word_o
);
   logic err_d;
   logic [WORD_W-1:0] tx_d;
   always_comb begin
      // an odd count of ones is a good word
      err_d = rx_valid_i && parity_en_i && !(^rx_word_i);
      tx_d = {tx_data_i, ~(^tx_data_i)};
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_parity_err_o <= 1'b0;
         tx_word_o <= '0;
      end else begin
         rx_parity_err_o <= err_d;
         tx_word_o <= tx_d;
      end
   end
endmodule

// >>> tb/scl_static_config_lock_chk.sv
// concurrent checks on the static configuration lock ports
`timescale 1ns/1ps
module scl_static_config_lock_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic reset_event_i,
   input wire logic [2:0] mode_i,
   input wire logic leave_configuration_command_i,
   input wire logic wr_i,
   input wire logic [3:0] wr_idx_i,
   input wire logic [15:0] wr_data_i,
   input wire logic rx_valid_i,
   input wire logic [15:0] rx_word_i,
   input wire logic [14:0] tx_data_i,
   input wire logic blanking_active_i,
   input wire logic frozen_o,
   input wire logic write_discarded_o,
   input wire logic reset_event_o,
   input wire logic class_b_event_o,
   input wire logic rx_parity_err_o,
   input wire logic [15:0] tx_word_o,
   input wire logic receive_parity_enable_o,
   input wire logic sense_clamp_o,
   input wire logic [7:0] regular_delay_value_o,
   input wire logic regular_two_level_turn_off_o,
   input wire logic [7:0] overcurrent_blanking_field_o,
   input wire logic overcurrent_immediate_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wr_take_a: assert property (
      wr_i && mode_i == 3'h2 && !frozen_o && wr_idx_i == 4'h2 && !reset_event_i
      |=> regular_delay_value_o == $past(wr_data_i[7:0])) else $error("accepted write lost");
   wr_refuse_a: assert property (
      wr_i && wr_idx_i < 4'h9 && (mode_i != 3'h2 || frozen_o) && !reset_event_i |=> write_discarded_o)
      else $error("refused write not flagged");
   freeze_set_a: assert property (
      leave_configuration_command_i && mode_i == 3'h2 && !reset_event_i |=> frozen_o) else $error("no freeze");
   freeze_hold_a: assert property (
      frozen_o && !reset_event_i |=> frozen_o) else $error("freeze dropped");
   soft_reset_a: assert property (
      reset_event_i |=> !frozen_o && receive_parity_enable_o && regular_delay_value_o == 8'h00)
      else $error("defaults not restored");
   rx_parity_a: assert property (
      1'b1 |=> rx_parity_err_o == ($past(rx_valid_i) && $past(receive_parity_enable_o) && !(^$past(rx_word_i))))
      else $error("receive parity wrong");
   tx_parity_a: assert property (
      1'b1 |=> tx_word_o == {$past(tx_data_i), ~^$past(tx_data_i)}) else $error("transmit parity wrong");
   hard_off_a: assert property (
      !reset_event_i |=> regular_two_level_turn_off_o == ($past(regular_delay_value_o) != 8'h00))
      else $error("two level flag");
   ovc_zero_a: assert property (
      !reset_event_i |=> overcurrent_immediate_o == ($past(overcurrent_blanking_field_o) == 8'h00))
      else $error("ovc flag");
   sense_blank_a: assert property (
      blanking_active_i && !reset_event_i |=> sense_clamp_o) else $error("sense pin not clamped");
   copy_match_a: assert property (
      !reset_event_o && !class_b_event_o) else $error("copy mismatch event");
endmodule

// >>> tb/scl_pwm_src.sv
// pwm pin and start-stop oscillator source for calibration and clamp timing
`timescale 1ns/1ps
module scl_pwm_src (
   output logic pwm_o,
   output logic osc_o
);
   initial begin
      pwm_o = 1'b0;
      osc_o = 1'b0;
   end
   // oscillator stands still outside a pulse so no stray edge reaches the counter
   task automatic pulse(input int edges, input int lead_ns);
      pwm_o = 1'b1;
      #(lead_ns);
      repeat (edges) begin
         osc_o = 1'b1;
         #40;
         osc_o = 1'b0;
         #40;
      end
      #(lead_ns);
      pwm_o = 1'b0;
   endtask
endmodule

// >>> tb/scl_static_config_lock_bench.sv
// self-checking bench for the static configuration lock
`timescale 1ns/1ps
`define CHK(k, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("[FAIL] out%0d exp %h got %h", k, e, g); end end
module scl_static_config_lock_bench;
   typedef struct {int k; logic [15:0] v;} scl_note_t;
   localparam logic [15:0] MASK [9] = '{16'h0001, 16'h000D, 16'h0FFF, 16'h0FFF, 16'h00FF, 16'h00FF, 16'h00FF,
      16'h0000, 16'h0001};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic reset_event_i = 1'b0;
   logic [2:0] mode_i = 3'h2;
   logic leave_configuration_command_i = 1'b0;
   logic wr_i = 1'b0;
   logic [3:0] wr_idx_i = 4'h0;
   logic [15:0] wr_data_i = 16'h0000, rx_word_i = 16'h0000, d;
   logic rx_valid_i = 1'b0, pwm_off_cmd_i = 1'b0, blanking_active_i = 1'b0;
   logic [14:0] tx_data_i = 15'h0000;
   logic pwm_i, osc_i, frozen_o, write_discarded_o, reset_event_o, class_b_event_o, rx_parity_err_o;
   logic receive_parity_enable_o, base_emitter_compensation_enable_o, pulse_suppressor_enable_o;
   logic verification_timeout_select_o, sense_clamp_o, regular_two_level_turn_off_o, safe_two_level_turn_off_o;
   logic overcurrent_immediate_o, calibration_enable_field_o, calibration_done_o, active_clamp_control_output_o;
   logic [15:0] tx_word_o;
   logic [7:0] regular_delay_value_o, safe_delay_value_o, saturation_blanking_a_o, saturation_blanking_b_o;
   logic [7:0] overcurrent_blanking_field_o;
   logic [3:0] regular_plateau_level_o, safe_plateau_level_o;
   logic [15:0] cur [9] = '{default: 16'h0000};
   int fails = 0;
   int cmp_count = 0;
   event probe_ev;
   scl_note_t exp_q[$];
   scl_note_t n;
   // timed clamp divider shortened so a clamp window lasts a few cycles
   scl_static_config_lock #(.CLAMP_DIV(4)) dut (.*);
   scl_pwm_src src (.pwm_o(pwm_i), .osc_o(osc_i));
   always #2.5 clk_i = ~clk_i;
   function automatic logic [15:0] seen(input int k);
      case (k)
         0: seen = 16'(receive_parity_enable_o);
         1: seen = {12'h000, verification_timeout_select_o, pulse_suppressor_enable_o, 1'b0,
            base_emitter_compensation_enable_o};
         2: seen = {4'h0, regular_plateau_level_o, regular_delay_value_o};
         3: seen = {4'h0, safe_plateau_level_o, safe_delay_value_o};
         4: seen = 16'(saturation_blanking_a_o);
         5: seen = 16'(saturation_blanking_b_o);
         6: seen = 16'(overcurrent_blanking_field_o);
         7: seen = 16'(active_clamp_control_output_o);
         8: seen = 16'(calibration_enable_field_o);
         9: seen = 16'(frozen_o);
         10: seen = 16'(write_discarded_o);
         11: seen = 16'(rx_parity_err_o);
         12: seen = tx_word_o;
         13: seen = 16'({safe_two_level_turn_off_o, regular_two_level_turn_off_o});
         14: seen = 16'(overcurrent_immediate_o);
         15: seen = 16'(sense_clamp_o);
         default: seen = 16'(calibration_done_o);
      endcase
   endfunction
   always @(probe_ev) begin
      while (exp_q.size() > 0) begin
         n = exp_q.pop_front();
         `CHK(n.k, n.v, seen(n.k))
      end
   end
   task automatic note(input int k, input logic [15:0] v);
      exp_q.push_back('{k, v});
   endtask
   task automatic tick(input int c);
      repeat (c) @(negedge clk_i);
   endtask
   task automatic wr(input int i, input logic [15:0] v, input logic refused);
      wr_i = 1'b1;
      wr_idx_i = 4'(i);
      wr_data_i = v;
      tick(1);
      wr_i = 1'b0;
      note(10, 16'(refused));
      ->probe_ev;
      tick(2);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      #200000;
      fails++;
      summarize();
   end
   initial begin
      d = 16'($urandom(32'hE91FD9A6));
      tick(5);
      rst_i = 1'b0;
      tick(1);
      note(0, 16'h0001);
      note(2, 16'h0000);
      note(7, 16'h0001);
      note(14, 16'h0001);
      ->probe_ev;
      // first pass writes zero to every register except clamp timing so the zero-value cases are hit
      for (int j = 0; j < 4; j++) begin
         for (int i = 0; i < 9; i++) begin
            if (i != 7) begin
               d = (j == 0) ? 16'h0000 : 16'($urandom());
               // safe delay above regular, safe plateau below regular, overcurrent blanking below saturation
               if (j != 0) begin
                  case (i)
                     2: d[11:7] = {1'b1, d[10:8], 1'b0};
                     3: d[11:7] = {1'b0, d[10:8], 1'b1};
                     4, 5: d[7] = 1'b1;
                     6: d[7] = 1'b0;
                     default: ;
                  endcase
               end
               wr(4'(i), d, 1'b0);
               cur[i] = d & MASK[i];
               note(i, cur[i]);
               note(13, 16'({cur[3][7:0] != 8'h00, cur[2][7:0] != 8'h00}));
               note(14, 16'(cur[6][7:0] == 8'h00));
               ->probe_ev;
            end
         end
      end
      wr(7, 16'h0000, 1'b0);
      note(7, 16'h0001);
      wr(7, 16'h00FF, 1'b0);
      note(7, 16'h0000);
      wr(7, 16'h0003, 1'b0);
      src.pulse(0, 60);
      tick(5);
      note(7, 16'h0000);
      ->probe_ev;
      // a short turn-on pulse inside the running window must not release the clamp
      src.pulse(0, 5);
      tick(1);
      note(7, 16'h0000);
      ->probe_ev;
      tick(20);
      note(7, 16'h0001);
      for (int p = 0; p < 2; p++) begin
         wr(0, 16'(p), 1'b0);
         repeat (8) begin
            rx_word_i = 16'($urandom());
            tx_data_i = 15'($urandom());
            rx_valid_i = 1'b1;
            tick(1);
            rx_valid_i = 1'b0;
            note(11, 16'(p == 1 && !(^rx_word_i)));
            note(12, {tx_data_i, ~^tx_data_i});
            ->probe_ev;
         end
      end
      wr(1, 16'h0002, 1'b0);
      pwm_off_cmd_i = 1'b1;
      tick(2);
      note(15, 16'h0001);
      wr(1, 16'h0000, 1'b0);
      note(15, 16'h0000);
      ->probe_ev;
      blanking_active_i = 1'b1;
      tick(2);
      note(15, 16'h0001);
      ->probe_ev;
      blanking_active_i = 1'b0;
      wr(8, 16'h0001, 1'b0);
      mode_i = 3'h6;
      tick(3);
      src.pulse(9, 40);
      tick(8);
      note(2, {4'h0, cur[2][11:8], 8'h09});
      note(17, 16'h0001);
      mode_i = 3'h4;
      wr(4, ~cur[4], 1'b1);
      note(4, cur[4]);
      mode_i = 3'h2;
      leave_configuration_command_i = 1'b1;
      tick(1);
      leave_configuration_command_i = 1'b0;
      tick(1);
      note(9, 16'h0001);
      wr(3, ~cur[3], 1'b1);
      note(3, cur[3]);
      tick(30);
      note(9, 16'h0001);
      ->probe_ev;
      reset_event_i = 1'b1;
      tick(1);
      reset_event_i = 1'b0;
      tick(2);
      note(9, 16'h0000);
      note(0, 16'h0001);
      note(2, 16'h0000);
      ->probe_ev;
      wr(2, 16'h0005, 1'b0);
      note(2, 16'h0005);
      ->probe_ev;
      tick(2);
      summarize();
   end
endmodule
bind scl_static_config_lock scl_static_config_lock_chk chk (.*);
